// ==== design/usb_gen_defines.svh ====
`ifndef USB_GEN_DEFINES_SVH
`define USB_GEN_DEFINES_SVH
// command codes on the low data byte
`define CMD_UNLOCK 8'hb0
`define CMD_SCRATCH_WR 8'hb2
`define CMD_SCRATCH_RD 8'hb3
`define CMD_FRAME_RD 8'hb4
`define CMD_PART_ID_RD 8'hb5
`define CMD_EVENTS_RD 8'hc0
// unlock key and field layouts
`define UNLOCK_KEY 16'haa37
`define SCRATCH_MSB 12
`define FRAME_MSB 10
`define SCRATCH_RESET 13'h0000
`define FRAME_RESET 11'h000
`define EVENTS_RESET 24'h000000
// event bit positions
`define EV_BUS_RESET 0
`define EV_RESUME 1
`define EV_SLEEP_ENTRY 2
`define EV_XFER_DONE 3
`define EV_FRAME 4
`define EV_PSEUDO_FRAME 5
`define EV_SHORT_PKT 6
`define EV_BUS_SLEEP 7
`define EV_ENDPOINT_LSB 8
`define EV_ENDPOINT_MSB 23
`define MISSED_FRAMES_LIMIT 2'd3
// timing: pseudo frame period
`define PSEUDO_FRAME_NS 1000000
`define CLK_PERIOD_NS 25
`define PSEUDO_FRAME_CYCLES (`PSEUDO_FRAME_NS / `CLK_PERIOD_NS)
// host wishbone register byte offsets
`define HOST_CTRL_ADDR 8'h00
`define HOST_WDATA_ADDR 8'h04
`define HOST_RDATA0_ADDR 8'h08
`define HOST_RDATA1_ADDR 8'h0c
`define HOST_STATUS_ADDR 8'h10
`endif

// ==== design/usb_gen_device.sv ====
`timescale 1ns/1ps
`include "usb_gen_defines.svh"
// How it works
// - key write lifts write protection
// - sleep entry blocks writes until the key; reads need unlock
// - processor sends unlock code, one word
// - scratch written and read, one word each
// - scratch holds 13 bits, resets zero
// - frame read returns last good frame
// - frame number sits in bits 10:0
// - frame undefined after bus reset
// - identity word: part code, version
// - version byte is BCD
// - firmware checks identity before use
// - event register read as two words
// - endpoint flags in bits 23 to 8
// - enable register gates event sources
// - bit 7 shows live sleep state
// - bit 6 on short packet transfer end
// - bit 5 on each pseudo frame tick
// - three missed frames enter sleep
// - bit 4 on frame detected
// - bit 3 on transfer counter zero
// - bit 2 on awake to sleep change
// - bit 1 on resume detected while asleep
// - bit 0 on bus reset detected
module usb_gen_device
  import usb_gen_pkg::*;
#(
  parameter int unsigned PSEUDO_CYCLES = `PSEUDO_FRAME_CYCLES,
  parameter logic [7:0] PART_CODE = 8'h5a, // arbitrary value
  parameter logic [7:0] SILICON_VERSION = 8'h10 // arbitrary value, BCD
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  usb_gen_if.dev bus,
  input wire logic frame_valid_i,
  input wire logic [10:0] frame_number_i,
  input wire logic bus_reset_i,
  input wire logic resume_i,
  input wire logic xfer_done_i,
  input wire logic short_packet_i,
  input wire logic [15:0] endpoint_event_i,
  input wire logic [23:0] event_enable_i,
  output logic bus_sleep_state_o,
  output logic write_locked_o
);
  opcode_t cmd_q;
  logic word_idx_q;
  logic locked_q;
  logic sleep_q;
  logic [`SCRATCH_MSB:0] scratch_q;
  logic [`FRAME_MSB:0] frame_q;
  word_t dat_r_q;
  logic rd_vld_q;
  logic [23:0] snap_q;
  logic [31:0] pseudo_cnt_q;
  logic pseudo_tick;
  logic [1:0] missed_q;
  logic frame_seen_q;
  logic sleep_enter;
  logic data_wr;
  logic data_rd;
  logic [23:0] ev_set;
  logic [23:0] ev_clr;
  logic [23:0] ev_flags;
  logic [31:0] events;

  // data phases on a0 low, command phase on a0 high
  assign data_wr = bus.wr_stb && !bus.a0;
  assign data_rd = bus.rd_stb && !bus.a0;

  // latch the command code from the low byte; high byte ignored
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cmd_q <= 8'h00;
    else if (bus.wr_stb && bus.a0)
      cmd_q <= bus.dat_w[7:0];
  end

  // word counter for two-word reads, restarted by each command
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      word_idx_q <= 1'b0;
    else if (bus.wr_stb && bus.a0)
      word_idx_q <= 1'b0;
    else if (data_rd && cmd_q == `CMD_EVENTS_RD)
      word_idx_q <= !word_idx_q;
  end

  // pseudo frame timer runs while awake
  assign pseudo_tick = !sleep_q && pseudo_cnt_q == 32'(PSEUDO_CYCLES - 1);
  always_ff @(posedge clk_i)
  begin
    if (rst_i || sleep_q || pseudo_tick)
      pseudo_cnt_q <= 32'h00000000;
    else
      pseudo_cnt_q <= pseudo_cnt_q + 32'h00000001;
  end

  // remember whether a frame arrived within the current period
  always_ff @(posedge clk_i)
  begin
    if (rst_i || pseudo_tick)
      frame_seen_q <= 1'b0;
    else if (frame_valid_i)
      frame_seen_q <= 1'b1;
  end

  // count consecutive missed frames
  always_ff @(posedge clk_i)
  begin
    if (rst_i || frame_valid_i || sleep_q)
      missed_q <= 2'd0;
    else if (pseudo_tick)
      missed_q <= frame_seen_q ? 2'd0 : missed_q + 2'd1;
  end
  assign sleep_enter = pseudo_tick && !frame_seen_q
    && missed_q == `MISSED_FRAMES_LIMIT - 2'd1;

  // bus sleep state: entered on missed frames, left on resume or reset
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      sleep_q <= 1'b0;
    else if (resume_i || bus_reset_i)
      sleep_q <= 1'b0;
    else if (sleep_enter)
      sleep_q <= 1'b1;
  end

  // write protection armed on sleep, lifted by the exact key
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      locked_q <= 1'b0;
    else if (data_wr && cmd_q == `CMD_UNLOCK && bus.dat_w == `UNLOCK_KEY)
      locked_q <= 1'b0;
    else if (sleep_enter)
      locked_q <= 1'b1;
  end

  // scratch word: stored only when unlocked, reserved bits dropped
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      scratch_q <= `SCRATCH_RESET;
    else if (data_wr && cmd_q == `CMD_SCRATCH_WR && !locked_q)
      scratch_q <= bus.dat_w[`SCRATCH_MSB:0];
  end

  // last good frame number; value after bus reset is not guaranteed
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      frame_q <= `FRAME_RESET;
    else if (frame_valid_i)
      frame_q <= frame_number_i;
  end

  // event sources, each gated by its enable bit
  always_comb
  begin
    ev_set = 24'h000000;
    ev_set[`EV_BUS_RESET] = bus_reset_i;
    ev_set[`EV_RESUME] = resume_i && sleep_q;
    ev_set[`EV_SLEEP_ENTRY] = sleep_enter;
    ev_set[`EV_XFER_DONE] = xfer_done_i;
    ev_set[`EV_FRAME] = frame_valid_i;
    ev_set[`EV_PSEUDO_FRAME] = pseudo_tick;
    ev_set[`EV_SHORT_PKT] = xfer_done_i && short_packet_i;
    ev_set[`EV_ENDPOINT_MSB:`EV_ENDPOINT_LSB] = endpoint_event_i;
    ev_set = ev_set & event_enable_i;
  end

  // flags read in the first word are cleared after the second word
  assign ev_clr = (data_rd && cmd_q == `CMD_EVENTS_RD && word_idx_q) ? snap_q : 24'h000000;

  // sticky event flags, except bit 7 which follows the live sleep state
  genvar i;
  generate
    for (i = 0; i < 24; i++)
    begin : g_flag
      if (i == `EV_BUS_SLEEP)
      begin : g_live
        assign ev_flags[i] = sleep_q;
      end
      else
      begin : g_sticky
        usb_gen_flag u_flag
        (
          .clk_i(clk_i),
          .rst_i(rst_i),
          .set_i(ev_set[i]),
          .clr_i(ev_clr[i]),
          .flag_o(ev_flags[i])
        );
      end
    end
  endgenerate
  assign events = {8'h00, ev_flags};

  // snapshot of flags taken at the first word
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      snap_q <= `EVENTS_RESET;
    else if (data_rd && cmd_q == `CMD_EVENTS_RD && !word_idx_q)
      snap_q <= ev_flags & ~(24'h1 << `EV_BUS_SLEEP);
  end

  // read data, answered one cycle after the strobe
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dat_r_q <= 16'h0000;
      rd_vld_q <= 1'b0;
    end
    else
    begin
      rd_vld_q <= data_rd;
      if (data_rd)
      begin
        if (locked_q)
          dat_r_q <= 16'h0000;
        else
        begin
          case (cmd_q)
            `CMD_SCRATCH_RD: dat_r_q <= {3'b000, scratch_q};
            `CMD_FRAME_RD: dat_r_q <= {5'b00000, frame_q};
            `CMD_PART_ID_RD: dat_r_q <= {PART_CODE, SILICON_VERSION};
            `CMD_EVENTS_RD: dat_r_q <= word_idx_q ? events[31:16] : events[15:0];
            default: dat_r_q <= 16'h0000;
          endcase
        end
      end
    end
  end

  assign bus.dat_r = dat_r_q;
  assign bus.rd_vld = rd_vld_q;
  assign bus_sleep_state_o = sleep_q;
  assign write_locked_o = locked_q;
endmodule

// ==== design/usb_gen_flag.sv ====
`timescale 1ns/1ps
// sticky event flag: a set in the clearing cycle wins
module usb_gen_flag
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic set_i,
  input wire logic clr_i,
  output logic flag_o
);
  logic flag_q;
  // set has priority over clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      flag_q <= 1'b0;
    else if (set_i)
      flag_q <= 1'b1;
    else if (clr_i)
      flag_q <= 1'b0;
  end
  assign flag_o = flag_q;
endmodule

// ==== design/usb_gen_host.sv ====
`timescale 1ns/1ps
`include "usb_gen_defines.svh"
// processor end: wishbone registers drive command sequences on the bus
module usb_gen_host
  import usb_gen_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  usb_gen_if.host bus
);
  host_state_e state_q;
  opcode_t op_q;
  word_t wdata_q;
  word_t rdata0_q;
  word_t rdata1_q;
  logic word_q;
  logic ack_q;
  logic [31:0] dat_o_q;
  logic a0_q;
  logic wr_q;
  logic rd_q;
  word_t dat_w_q;
  logic wb_req;
  logic start;
  logic is_write;
  logic is_two;

  assign wb_req = cyc_i && stb_i && !ack_q;
  assign start = wb_req && we_i && sel_i[0] && adr_i == `HOST_CTRL_ADDR && state_q == HS_IDLE;
  assign is_write = op_q == `CMD_UNLOCK || op_q == `CMD_SCRATCH_WR;
  assign is_two = op_q == `CMD_EVENTS_RD;

  // wishbone answer one cycle after the request
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
      dat_o_q <= 32'h00000000;
      wdata_q <= 16'h0000;
    end
    else
    begin
      ack_q <= wb_req;
      if (wb_req && we_i && adr_i == `HOST_WDATA_ADDR)
      begin
        if (sel_i[0])
          wdata_q[7:0] <= dat_i[7:0];
        if (sel_i[1])
          wdata_q[15:8] <= dat_i[15:8];
      end
      case (adr_i)
        `HOST_CTRL_ADDR: dat_o_q <= {24'h000000, op_q};
        `HOST_WDATA_ADDR: dat_o_q <= {16'h0000, wdata_q};
        `HOST_RDATA0_ADDR: dat_o_q <= {16'h0000, rdata0_q};
        `HOST_RDATA1_ADDR: dat_o_q <= {16'h0000, rdata1_q};
        `HOST_STATUS_ADDR: dat_o_q <= {31'h00000000, state_q != HS_IDLE};
        default: dat_o_q <= 32'h00000000;
      endcase
    end
  end

  // command sequencer: command phase, then one or two data words
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_q <= HS_IDLE;
      op_q <= 8'h00;
      word_q <= 1'b0;
      a0_q <= 1'b0;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      dat_w_q <= 16'h0000;
      rdata0_q <= 16'h0000;
      rdata1_q <= 16'h0000;
    end
    else
    begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      case (state_q)
        HS_IDLE:
          if (start)
          begin
            op_q <= dat_i[7:0];
            word_q <= 1'b0;
            state_q <= HS_CMD;
          end
        HS_CMD:
        begin
          a0_q <= 1'b1;
          wr_q <= 1'b1;
          dat_w_q <= {8'h00, op_q};
          state_q <= HS_DATA;
        end
        HS_DATA:
        begin
          a0_q <= 1'b0;
          if (is_write)
          begin
            wr_q <= 1'b1;
            dat_w_q <= wdata_q;
            state_q <= HS_IDLE;
          end
          else
          begin
            rd_q <= 1'b1;
            state_q <= HS_WAIT;
          end
        end
        HS_WAIT:
          if (bus.rd_vld)
          begin
            if (word_q)
              rdata1_q <= bus.dat_r;
            else
              rdata0_q <= bus.dat_r;
            word_q <= 1'b1;
            state_q <= (is_two && !word_q) ? HS_DATA : HS_IDLE;
          end
        default: state_q <= HS_IDLE;
      endcase
    end
  end

  assign dat_o = dat_o_q;
  assign ack_o = ack_q;
  assign bus.a0 = a0_q;
  assign bus.wr_stb = wr_q;
  assign bus.rd_stb = rd_q;
  assign bus.dat_w = dat_w_q;
endmodule

// ==== design/usb_gen_if.sv ====
`timescale 1ns/1ps
// shared parallel command/data bus between processor and device
interface usb_gen_if;
  logic a0;
  logic wr_stb;
  logic rd_stb;
  logic [15:0] dat_w;
  logic [15:0] dat_r;
  logic rd_vld;
  modport dev (input a0, input wr_stb, input rd_stb, input dat_w, output dat_r, output rd_vld);
  modport host (output a0, output wr_stb, output rd_stb, output dat_w, input dat_r, input rd_vld);
endinterface

// ==== design/usb_gen_pkg.sv ====
package usb_gen_pkg;
  typedef logic [15:0] word_t;
  typedef logic [7:0] opcode_t;
  typedef enum logic [2:0]
  {
    HS_IDLE = 3'b000,
    HS_CMD = 3'b001,
    HS_DATA = 3'b010,
    HS_WAIT = 3'b011,
    HS_GAP = 3'b100
  } host_state_e;
endpackage

// ==== dv/usb_device_general_commands_tb.sv ====
`timescale 1ns/1ps
`include "usb_gen_defines.svh"
module usb_device_general_commands_tb import usb_gen_pkg::*;;
  localparam int unsigned PSC = 100;
  localparam logic [7:0] PART = 8'h3c; // arbitrary value
  localparam logic [7:0] VER = 8'h27; // arbitrary value, decimal digits
  logic clk_i, rst_i, cyc, stb, we, ack, fv, frames_on;
  logic [7:0] adr;
  logic [31:0] wdat, rdat, v;
  logic [10:0] fnum, fno;
  logic xfer, shortp, bus_rst, resume, sleep, locked;
  logic [15:0] ep;
  logic [23:0] en;
  logic [15:0] sv [2] = '{16'h1fff, 16'h0a5a};
  int n_mismatch = 0;
  int checked = 0;
  usb_gen_if bus();
  usb_gen_host i_usb_gen_host (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(4'hf), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
    .bus(bus));
  usb_gen_device #(.PSEUDO_CYCLES(PSC), .PART_CODE(PART), .SILICON_VERSION(VER))
    i_usb_gen_device (.clk_i(clk_i), .rst_i(rst_i), .bus(bus), .frame_valid_i(fv),
    .frame_number_i(fno), .bus_reset_i(bus_rst), .resume_i(resume), .xfer_done_i(xfer),
    .short_packet_i(shortp), .endpoint_event_i(ep), .event_enable_i(en),
    .bus_sleep_state_o(sleep), .write_locked_o(locked));
  usb_gen_assertions i_usb_gen_assertions (.clk_i(clk_i), .rst_i(rst_i), .a0(bus.a0),
    .wr_stb(bus.wr_stb), .rd_stb(bus.rd_stb), .dat_w(bus.dat_w), .dat_r(bus.dat_r),
    .rd_vld(bus.rd_vld));
  // compare and count
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // verdict and end of run
  task final_report();
    $display("compares %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // one classic wishbone cycle, held until ack
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    // only the watchdog ends a wait for ack
    do
    begin
      @(posedge clk_i);
    end
    while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // issue one command and wait until the host is idle
  task run(input logic [7:0] op, input logic [15:0] d);
    logic [31:0] q;
    wb(1'b1, `HOST_WDATA_ADDR, {16'h0000, d}, q);
    wb(1'b1, `HOST_CTRL_ADDR, {24'h000000, op}, q);
    q = 32'h1;
    while (q[0] !== 1'b0)
    begin
      wb(1'b0, `HOST_STATUS_ADDR, 32'h0, q);
    end
  endtask
  // single word read command
  task rd1(input logic [7:0] op, output logic [31:0] q);
    run(op, 16'h0000);
    wb(1'b0, `HOST_RDATA0_ADDR, 32'h0, q);
  endtask
  // two word event read
  task rdev(output logic [31:0] q);
    logic [31:0] lo, hi;
    run(`CMD_EVENTS_RD, 16'h0000);
    wb(1'b0, `HOST_RDATA0_ADDR, 32'h0, lo);
    wb(1'b0, `HOST_RDATA1_ADDR, 32'h0, hi);
    q = {hi[15:0], lo[15:0]};
  endtask
  // one-cycle event pulses: transfer, short, bus reset, resume
  task kick(input logic [15:0] e, input logic [3:0] m);
    @(posedge clk_i);
    ep <= e;
    {xfer, shortp, bus_rst, resume} <= m;
    @(posedge clk_i);
    ep <= 16'h0000;
    {xfer, shortp, bus_rst, resume} <= 4'h0;
  endtask
  // clock
  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // good frame packets every eleven cycles while enabled
  initial
  begin
    fv = 1'b0;
    fno = 11'h000;
    forever
    begin
      repeat (10) @(posedge clk_i);
      fv <= frames_on;
      fno <= fnum;
      @(posedge clk_i);
      fv <= 1'b0;
    end
  end
  // watchdog
  initial
  begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    final_report();
  end
  // main sequence
  initial
  begin
    {cyc, stb, we, adr, wdat} = '0;
    {xfer, shortp, bus_rst, resume, ep, en} = '0;
    frames_on = 1'b1;
    fnum = 11'h123;
    rst_i = 1'b1;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rd1(`CMD_SCRATCH_RD, v);
    check(v, 32'h0);
    for (int i = 0; i < 2; i++)
    begin
      run(`CMD_SCRATCH_WR, sv[i]);
      rd1(`CMD_SCRATCH_RD, v);
      check(v, {16'h0000, sv[i]});
    end
    rd1(`CMD_PART_ID_RD, v);
    check(v, {16'h0000, PART, VER});
    wb(1'b0, 8'h20, 32'h0, v);
    check(v, 32'h0);
    fnum <= 11'h7a5;
    repeat (25) @(posedge clk_i);
    rd1(`CMD_FRAME_RD, v);
    check(v, 32'h07a5);
    en <= 24'hffff00;
    rdev(v);
    kick(16'h8001, 4'h0);
    rdev(v);
    check(v, 32'h00800100);
    kick(16'h0002, 4'h0);
    rdev(v);
    check(v, 32'h00000200);
    en <= 24'h000000;
    kick(16'h4000, 4'h0);
    en <= 24'hffff00;
    rdev(v);
    check(v, 32'h0);
    frames_on <= 1'b0;
    en <= 24'h00004f;
    kick(16'h0000, 4'b1110);
    rdev(v);
    check(v, 32'h49);
    kick(16'h0000, 4'b1000);
    rdev(v);
    check(v, 32'h08);
    en <= 24'h0000ff;
    rdev(v);
    repeat (5 * PSC) @(posedge clk_i);
    check(sleep, 1'b1);
    check(locked, 1'b1);
    rd1(`CMD_SCRATCH_RD, v);
    check(v, 32'h0);
    run(`CMD_SCRATCH_WR, 16'h0123);
    run(`CMD_UNLOCK, 16'haa36);
    check(locked, 1'b1);
    run(`CMD_UNLOCK, 16'haa37);
    check(locked, 1'b0);
    rdev(v);
    check(v, 32'ha4);
    rd1(`CMD_SCRATCH_RD, v);
    check(v, 32'h0a5a);
    en <= 24'h000002;
    rdev(v);
    frames_on <= 1'b1;
    kick(16'h0000, 4'b0001);
    @(posedge clk_i);
    check(sleep, 1'b0);
    rdev(v);
    check(v, 32'h02);
    // frame flag alone, with good frames arriving again
    en <= 24'h000010;
    repeat (15) @(posedge clk_i);
    rdev(v);
    check(v, 32'h10);
    // unknown command code reads zero
    rd1(8'ha0, v);
    check(v, 32'h0);
    final_report();
  end
endmodule

// ==== dv/usb_gen_assertions.sv ====
`timescale 1ns/1ps
`include "usb_gen_defines.svh"
// protocol checks on the command/data link
module usb_gen_assertions
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic a0,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [15:0] dat_w,
  input wire logic [15:0] dat_r,
  input wire logic rd_vld
);
  logic [7:0] cmd_q;
  logic [1:0] nrd_q;
  logic cmd;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  assign cmd = wr_stb && a0;
  // last command code and words answered since it
  always_ff @(posedge clk_i)
  begin
    if (rst_i || cmd)
    begin
      cmd_q <= rst_i ? 8'h00 : dat_w[7:0];
      nrd_q <= 2'h0;
    end
    else if (rd_vld)
      nrd_q <= nrd_q + 2'h1;
  end
  chk_read_answer: assert property (rd_stb |=> rd_vld)
    else $error("read strobe got no answer");
  chk_answer_cause: assert property (rd_vld |-> $past(rd_stb))
    else $error("answer without read strobe");
  chk_data_hold: assert property ($changed(dat_r) |-> rd_vld)
    else $error("read data moved without answer");
  chk_read_phase: assert property (rd_stb |-> !a0 && !wr_stb)
    else $error("read strobe outside data phase");
  chk_key_one_word: assert property (cmd && (dat_w[7:0] == `CMD_UNLOCK ||
    dat_w[7:0] == `CMD_SCRATCH_WR) |=> wr_stb && !a0 ##1 !wr_stb)
    else $error("write command not followed by one word");
  chk_single_read: assert property (cmd && dat_w[7:0] inside {`CMD_SCRATCH_RD,
    `CMD_FRAME_RD, `CMD_PART_ID_RD} |=> rd_stb && !a0 ##1 !rd_stb[*3])
    else $error("read command not followed by one read");
  chk_event_pair: assert property (cmd && dat_w[7:0] == `CMD_EVENTS_RD
    |=> rd_stb ##3 rd_stb)
    else $error("event read not two words");
  chk_scratch_width: assert property (rd_vld && cmd_q == `CMD_SCRATCH_RD
    |-> dat_r[15:13] == 3'h0)
    else $error("scratch upper bits set");
  chk_frame_width: assert property (rd_vld && cmd_q == `CMD_FRAME_RD
    |-> dat_r[15:11] == 5'h00)
    else $error("frame reserved bits set");
  chk_version_bcd: assert property (rd_vld && cmd_q == `CMD_PART_ID_RD && dat_r != 16'h0
    |-> dat_r[7:4] < 4'ha && dat_r[3:0] < 4'ha)
    else $error("version byte not decimal");
  chk_event_top: assert property (rd_vld && cmd_q == `CMD_EVENTS_RD && nrd_q == 2'h1
    |-> dat_r[15:8] == 8'h00)
    else $error("event top byte set");
  cov_event_read: cover property (rd_vld && cmd_q == `CMD_EVENTS_RD && nrd_q == 2'h1);
  cov_unlock: cover property (cmd && dat_w[7:0] == `CMD_UNLOCK);
  cov_frame_read: cover property (rd_vld && cmd_q == `CMD_FRAME_RD);
endmodule
